// File: core/ptp_ts_cfg.svh
// Constants for the precision-time stamp ports: field positions, timer limits
// and clock figures shared by both ends.
// Assumes it is included by its bare name, before the package.
`ifndef PTP_TS_CFG_SVH
`define PTP_TS_CFG_SVH

// Stamp word layout
`define STAMP_W 128
`define TOD_NS_LSB 0
`define TOD_NS_MSB 31
`define TOD_SEC_LSB 32
`define TOD_SEC_MSB 79
`define CF_LSB 0
`define CF_MSB 63
`define TAG_LSB 80
`define TAG_MSB 95
`define CF_FRAC_BITS 16

// Timer limits
`define NS_PER_SEC 33'h3b9aca00
`define NS_WRAP_MAX 32'h3b9ac9ff

// Core clock and timer clock divider
`define CLK_PERIOD_NS 25
`define TIMER_HALF_DIV 2

`endif

// File: core/ptp_ts_client_end.sv
// Client end: makes both system timers and consumes the two stamp streams.
// Assumes the stamp end shares clk_i; timer clocks are divided from it.
`timescale 1ns/1ps
`default_nettype none
`include "ptp_ts_cfg.svh"

module ptp_ts_client_end
    import ptp_ts_pkg::*;
#(
    parameter int HALF_DIV = `TIMER_HALF_DIV
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // User side
    input wire logic format_cf_i,
    output logic [15:0] tx_tag_o,
    output logic [63:0] tx_time_o,
    output logic tx_seen_o,
    output logic [79:0] rx_time_o,
    output logic rx_seen_o,
    // Link side
    ptp_ts_if.client link
);

    localparam logic [32:0] STEP_NS = 33'(`CLK_PERIOD_NS * 2 * HALF_DIV);

    generate
        if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_bad_div
            $error("HALF_DIV out of range");
        end
    endgenerate

    client_state_s st;
    client_state_s next_st;
    logic [32:0] ns_sum;

    // Timer advance on each rising timer edge, stamp capture
    always_comb begin
        next_st = st;
        ns_sum = {1'b0, st.ns} + STEP_NS;
        next_st.tx_seen = 1'b0;
        next_st.rx_seen = 1'b0;
        if (st.div_cnt == 8'(HALF_DIV - 1)) begin
            next_st.div_cnt = 8'h00;
            next_st.timer_clk = ~st.timer_clk;
            if (!st.timer_clk) begin
                if (ns_sum >= `NS_PER_SEC) begin
                    next_st.ns = 32'(ns_sum - `NS_PER_SEC);
                    next_st.sec = st.sec + 48'h1;
                end else begin
                    next_st.ns = ns_sum[31:0];
                end
                next_st.cf = st.cf + {15'h0, STEP_NS, 16'h0};
            end
        end else begin
            next_st.div_cnt = st.div_cnt + 8'h01;
        end
        if (link.tx_stamp_valid) begin
            next_st.tx_tag = link.tx_stamp_word[`TAG_MSB:`TAG_LSB];
            next_st.tx_time = format_cf_i ? link.tx_stamp_word[`CF_MSB:`CF_LSB]
                                          : {32'h0, link.tx_stamp_word[`TOD_NS_MSB:`TOD_NS_LSB]};
            next_st.tx_seen = 1'b1;
        end
        if (link.rx_stamp_valid) begin
            next_st.rx_time = format_cf_i ? {16'h0, link.rx_stamp_word[`CF_MSB:`CF_LSB]}
                                          : link.rx_stamp_word[`TOD_SEC_MSB:`TOD_NS_LSB];
            next_st.rx_seen = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Timer outputs, both formats on the divided clock
    assign link.tod_clk = st.timer_clk;
    assign link.cf_clk = st.timer_clk;
    assign link.tod_sec = st.sec;
    assign link.tod_ns = st.ns;
    assign link.cf_timer = st.cf;
    // User outputs
    assign tx_tag_o = st.tx_tag;
    assign tx_time_o = st.tx_time;
    assign tx_seen_o = st.tx_seen;
    assign rx_time_o = st.rx_time;
    assign rx_seen_o = st.rx_seen;

endmodule : ptp_ts_client_end

`default_nettype wire

// File: core/ptp_ts_if.sv
// Interface joining the stamp-producing end and the client/timer end.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface ptp_ts_if;
    import ptp_ts_pkg::*;

    // Time-of-day timer with its own clock
    logic tod_clk;
    logic [47:0] tod_sec;
    logic [31:0] tod_ns;
    // Correction-field timer with its own clock
    logic cf_clk;
    logic [63:0] cf_timer;
    // Stamp streams
    stamp_t tx_stamp_word;
    logic tx_stamp_valid;
    stamp_t rx_stamp_word;
    logic rx_stamp_valid;

    modport mac (
        input tod_clk, tod_sec, tod_ns, cf_clk, cf_timer,
        output tx_stamp_word, tx_stamp_valid, rx_stamp_word, rx_stamp_valid
    );

    modport client (
        output tod_clk, tod_sec, tod_ns, cf_clk, cf_timer,
        input tx_stamp_word, tx_stamp_valid, rx_stamp_word, rx_stamp_valid
    );

endinterface : ptp_ts_if

`default_nettype wire

// File: core/ptp_ts_mac_end.sv
// Stamp end: samples both system timers and issues transmit and receive
// stamp words on two dedicated streams, each with a one-cycle valid.
// Assumes clk_i is the core output clock and all inputs are synchronous to
// it; timer clocks are sampled as ordinary inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ptp_ts_cfg.svh"

module ptp_ts_mac_end
    import ptp_ts_pkg::*;
#(
    parameter int TAG_W = 16,
    parameter int SEC_W = 48,
    parameter int NS_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Format select: low time-of-day, high correction field
    input wire logic format_cf_i,
    // Transmit frame event with its command tag
    input wire logic tx_frame_done_i,
    input wire logic [15:0] tx_tag_i,
    // Receive frame event
    input wire logic rx_frame_done_i,
    // Link side
    ptp_ts_if.mac link
);

    // The word layout is fixed; other widths cannot be served
    generate
        if (TAG_W != 16) begin : g_bad_tag
            $error("TAG_W must be 16");
        end
        if (SEC_W != 48) begin : g_bad_sec
            $error("SEC_W must be 48");
        end
        if (NS_W != 32) begin : g_bad_ns
            $error("NS_W must be 32");
        end
    endgenerate

    // Builds a stamp word from the sampled timer values.
    // Reserved fields always read as zero so a client that ignores
    // them and one that checks them both behave.
    function automatic stamp_t pack_stamp(
        input logic fmt_cf,
        input logic [47:0] sec,
        input logic [31:0] ns,
        input logic [63:0] cf,
        input logic [15:0] tag,
        input logic with_tag
    );
        stamp_t w;
        w = '0;
        if (fmt_cf) begin
            // Full 64-bit correction value, upper bits stay zero apart from the tag
            w[`CF_MSB:`CF_LSB] = cf;
        end else begin
            // Seconds above nanoseconds
            w[`TOD_NS_MSB:`TOD_NS_LSB] = ns;
            w[`TOD_SEC_MSB:`TOD_SEC_LSB] = sec;
        end
        if (with_tag) begin
            // Tag position is the same in both formats
            w[`TAG_MSB:`TAG_LSB] = tag;
        end
        return w;
    endfunction : pack_stamp

    mac_state_s st;
    mac_state_s next_st;
    logic tod_rise;
    logic cf_rise;

    // Rising edges of the two timer clocks
    assign tod_rise = link.tod_clk & ~st.tod_clk_prev;
    assign cf_rise = link.cf_clk & ~st.cf_clk_prev;

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.tod_clk_prev = link.tod_clk;
        next_st.cf_clk_prev = link.cf_clk;

        // Timer fields are only trusted at their own clock's edge
        if (tod_rise) begin
            next_st.tod_sec = link.tod_sec;
            next_st.tod_ns = link.tod_ns;
        end
        if (cf_rise) begin
            next_st.cf_time = link.cf_timer;
        end

        // Valids drop after one cycle unless another frame follows
        next_st.tx_valid = 1'b0;
        next_st.rx_valid = 1'b0;

        // Transmit stamp uses the value sampled before this cycle
        if (tx_frame_done_i) begin
            next_st.tx_word = pack_stamp(format_cf_i, st.tod_sec, st.tod_ns,
                                         st.cf_time, tx_tag_i, 1'b1);
            next_st.tx_valid = 1'b1;
        end

        // Every received frame gets its own stamp, no tag
        if (rx_frame_done_i) begin
            next_st.rx_word = pack_stamp(format_cf_i, st.tod_sec, st.tod_ns,
                                         st.cf_time, 16'h0000, 1'b0);
            next_st.rx_valid = 1'b1;
        end
    end

    // State register on the core clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Transmit stamp stream, separate from frame data
    assign link.tx_stamp_word = st.tx_word;
    assign link.tx_stamp_valid = st.tx_valid;

    // Receive stamp stream on the core clock
    assign link.rx_stamp_word = st.rx_word;
    assign link.rx_stamp_valid = st.rx_valid;

endmodule : ptp_ts_mac_end

`default_nettype wire

// File: core/ptp_ts_pkg.sv
// Types for the stamp ports: register state of each end.
// Assumes ptp_ts_cfg.svh is on the include path.
`default_nettype none
`include "ptp_ts_cfg.svh"

package ptp_ts_pkg;

    typedef logic [`STAMP_W-1:0] stamp_t;

    // Stamp side state
    typedef struct packed {
        logic tod_clk_prev;
        logic cf_clk_prev;
        logic [47:0] tod_sec;
        logic [31:0] tod_ns;
        logic [63:0] cf_time;
        stamp_t tx_word;
        logic tx_valid;
        stamp_t rx_word;
        logic rx_valid;
    } mac_state_s;

    // Timer source and stamp consumer state
    typedef struct packed {
        logic [7:0] div_cnt;
        logic timer_clk;
        logic [47:0] sec;
        logic [31:0] ns;
        logic [63:0] cf;
        logic [15:0] tx_tag;
        logic [63:0] tx_time;
        logic tx_seen;
        logic [79:0] rx_time;
        logic rx_seen;
    } client_state_s;

endpackage : ptp_ts_pkg

`default_nettype wire

// File: verif/ptp_ts_checker.sv
// Checker for the stamp streams and the day timer between both ends.
// Assumes the testbench wires it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module ptp_ts_checker
    import ptp_ts_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Device user side
    input wire logic format_cf_i,
    input wire logic tx_frame_done_i,
    input wire logic [15:0] tx_tag_i,
    input wire logic rx_frame_done_i,
    // Interface signals
    input wire logic [31:0] tod_ns,
    input wire stamp_t tx_stamp_word,
    input wire logic tx_stamp_valid,
    input wire stamp_t rx_stamp_word,
    input wire logic rx_stamp_valid
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Stamp timing and layout, day timer range
    AST_TX_LAT: assert property (tx_frame_done_i |=> tx_stamp_valid && tx_stamp_word[95:80] == $past(tx_tag_i))
        else $error("tx stamp late or tag wrong");
    AST_TX_ONE: assert property (!tx_frame_done_i |=> !tx_stamp_valid)
        else $error("tx valid without event");
    AST_RX_LAT: assert property (rx_frame_done_i |=> rx_stamp_valid)
        else $error("rx stamp missing");
    AST_RX_ONE: assert property (!rx_frame_done_i |=> !rx_stamp_valid)
        else $error("rx valid without event");
    AST_TX_HOLD: assert property (!tx_frame_done_i |=> $stable(tx_stamp_word))
        else $error("tx word moved between events");
    AST_TX_CF_RSV: assert property (tx_stamp_valid && $past(format_cf_i) |-> tx_stamp_word[79:64] == 16'h0)
        else $error("tx reserved field set");
    AST_RX_CF_RSV: assert property (rx_stamp_valid && $past(format_cf_i) |-> rx_stamp_word[127:64] == 64'h0)
        else $error("rx reserved field set");
    AST_RX_TOD_RSV: assert property (rx_stamp_valid && !$past(format_cf_i) |-> rx_stamp_word[127:80] == 48'h0)
        else $error("rx reserved field set");
    AST_NS_MAX: assert property (tod_ns <= 32'h3b9ac9ff)
        else $error("nanoseconds out of range");
endmodule : ptp_ts_checker
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench joining both ends through the interface.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ptp_ts_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic format_cf_i = 1'b0;
    logic tx_frame_done_i = 1'b0;
    logic [15:0] tx_tag_i = 16'h0;
    logic rx_frame_done_i = 1'b0;
    logic [15:0] tx_tag_o;
    logic [63:0] tx_time_o;
    logic tx_seen_o;
    logic [79:0] rx_time_o;
    logic rx_seen_o;
    int num_errors = 0;
    int check_count = 0;
    stamp_t exp_word;
    // Rows: format, transmit flag, tag
    logic [17:0] rows [5] = '{18'h10001, 18'h3ffff, 18'h00000, 18'h20000, 18'h18000};

    ptp_ts_if link_if ();
    ptp_ts_mac_end ptp_ts_mac_end_inst (.clk_i(clk_i), .rst_i(rst_i), .format_cf_i(format_cf_i),
        .tx_frame_done_i(tx_frame_done_i), .tx_tag_i(tx_tag_i), .rx_frame_done_i(rx_frame_done_i),
        .link(link_if.mac));
    ptp_ts_client_end #(.HALF_DIV(4)) ptp_ts_client_end_inst (.clk_i(clk_i), .rst_i(rst_i),
        .format_cf_i(format_cf_i), .tx_tag_o(tx_tag_o), .tx_time_o(tx_time_o), .tx_seen_o(tx_seen_o),
        .rx_time_o(rx_time_o), .rx_seen_o(rx_seen_o), .link(link_if.client));
    ptp_ts_checker ptp_ts_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .format_cf_i(format_cf_i),
        .tx_frame_done_i(tx_frame_done_i), .tx_tag_i(tx_tag_i), .rx_frame_done_i(rx_frame_done_i),
        .tod_ns(link_if.tod_ns), .tx_stamp_word(link_if.tx_stamp_word), .tx_stamp_valid(link_if.tx_stamp_valid),
        .rx_stamp_word(link_if.rx_stamp_word), .rx_stamp_valid(link_if.rx_stamp_valid));

    // Compare and count
    task automatic check(input logic [127:0] seen, input logic [127:0] expected);
        check_count++;
        if (seen !== expected) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // Verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // Reset for n cycles, outputs must be clear
    task automatic reset_for(input int n);
        rst_i = 1'b1;
        repeat (n) @(negedge clk_i);
        check(link_if.tx_stamp_word | link_if.rx_stamp_word, 128'h0);
        check({link_if.tx_stamp_valid, link_if.rx_stamp_valid, tx_seen_o, rx_seen_o, link_if.tod_clk}, 5'h00);
        rst_i = 1'b0;
        $display("reset test done");
    endtask : reset_for

    // One event well clear of a timer step, then stamp and consumer checks
    task automatic stamp(input logic fmt, input logic tx, input logic [15:0] tag);
        format_cf_i = fmt;
        @(posedge link_if.tod_clk);
        repeat (3) @(negedge clk_i);
        exp_word = fmt ? {64'h0, link_if.cf_timer} : {48'h0, link_if.tod_sec, link_if.tod_ns};
        if (tx) exp_word[127:80] = {32'h0, tag};
        tx_frame_done_i = tx;
        rx_frame_done_i = !tx;
        tx_tag_i = tag;
        @(negedge clk_i);
        tx_frame_done_i = 1'b0;
        rx_frame_done_i = 1'b0;
        check({link_if.tx_stamp_valid, link_if.rx_stamp_valid}, {tx, !tx});
        check(tx ? link_if.tx_stamp_word : link_if.rx_stamp_word, exp_word);
        @(negedge clk_i);
        check({link_if.tx_stamp_valid, link_if.rx_stamp_valid, tx ? tx_seen_o : rx_seen_o}, 3'b001);
        check(tx ? tx_tag_o : link_if.rx_stamp_word[95:80], tx ? tag : 16'h0);
        if (tx) check(tx_time_o, fmt ? exp_word[63:0] : {32'h0, exp_word[31:0]});
        if (!tx) check(rx_time_o, exp_word[79:0]);
    endtask : stamp

    // Clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end

    // Main sequence
    initial begin
        reset_for(8);
        for (int i = 0; i < 5; i++) begin
            stamp(rows[i][17], rows[i][16], rows[i][15:0]);
            $display("row %0d done", i);
        end
        // Back-to-back transmit beside one receive
        format_cf_i = 1'b0;
        tx_frame_done_i = 1'b1;
        rx_frame_done_i = 1'b1;
        tx_tag_i = 16'haaaa;
        @(negedge clk_i);
        check({link_if.tx_stamp_valid, link_if.rx_stamp_valid, link_if.tx_stamp_word[95:80]}, 18'h3aaaa);
        rx_frame_done_i = 1'b0;
        tx_tag_i = 16'h5555;
        @(negedge clk_i);
        check({link_if.tx_stamp_valid, link_if.rx_stamp_valid, link_if.tx_stamp_word[95:80]}, 18'h25555);
        tx_frame_done_i = 1'b0;
        @(negedge clk_i);
        check({link_if.tx_stamp_valid, link_if.tx_stamp_word[95:80]}, 17'h05555);
        $display("back-to-back test done");
        reset_for(2);
        stamp(1'b1, 1'b1, 16'h1234);
        $display("recovery test done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
